// ==== hw/dfa_defs.svh ====
// Purpose: constants for the debug flash access register block
// Assumes: 200 MHz core clock, debug link clock sampled as a plain input
// Notes:   offsets are debug-link register addresses
`ifndef DFA_DEFS_SVH
`define DFA_DEFS_SVH
`define DFA_ADDR_PART_ID    8'hfd
`define DFA_ADDR_SI_REV     8'hfe
`define DFA_ADDR_FP_CTRL    8'h02
`define DFA_ADDR_FP_DATA    8'hb4
`define DFA_SFR_PAGE_MIRROR 4'hf
`define DFA_FP_CTRL_RESET   8'h00
`define DFA_FP_DATA_RESET   8'h00
`define DFA_ADDR_SEL_RESET  8'h00
`define DFA_UNLOCK_CODE_1   8'h02
`define DFA_UNLOCK_CODE_2   8'h01
`define DFA_CMD_BLOCK_READ  8'h06
`define DFA_CMD_BLOCK_WRITE 8'h07
`define DFA_CMD_PAGE_ERASE  8'h08
`define DFA_CMD_DEV_ERASE   8'h03
`endif

// ==== hw/dfa_pkg.sv ====
// Purpose: types for the debug flash access register block
// Assumes: dfa_defs.svh carries the numbers
// Notes:   none
package dfa_pkg;
	typedef enum logic [2:0] {
		DFA_CMD_NONE,
		DFA_CMD_READ,
		DFA_CMD_WRITE,
		DFA_CMD_PAGE,
		DFA_CMD_DEVICE
	} dfa_cmd_t;
	typedef enum logic [1:0] {
		DFA_LOCKED,
		DFA_HALF,
		DFA_UNLOCKED
	} dfa_unlock_t;
endpackage : dfa_pkg

// ==== hw/dfa_sync_if.sv ====
// Purpose: carries synchronised link levels to the main block
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/10ps
interface dfa_sync_if;
	logic link_clk;
	logic link_data;
	modport src (output link_clk, output link_data);
	modport dst (input link_clk, input link_data);
endinterface : dfa_sync_if

// ==== hw/dfa_sync.sv ====
// Purpose: two-flop synchroniser for the debug link pins
// Assumes: pins are asynchronous to clock_i
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
module dfa_sync (
	input  wire logic  clock_i,
	input  wire logic  resetn_i,
	input  wire logic  link_clk_i,
	input  wire logic  link_data_i,
	dfa_sync_if.src    sync
);
	logic [1:0] meta_reg;
	logic [1:0] stable_reg;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			meta_reg   <= 2'h0;
			stable_reg <= 2'h0;
		end else begin
			meta_reg   <= {link_clk_i, link_data_i};
			stable_reg <= meta_reg;
		end
	end

	assign sync.link_clk  = stable_reg[1];
	assign sync.link_data = stable_reg[0];
endmodule : dfa_sync

// ==== hw/dfa_regs.sv ====
// Purpose: device-side debug link registers for flash programming
// Assumes: link transfers decoded upstream into address/data strobes
// Notes:   bit-level link protocol and flash timing lie outside
`timescale 1ns/10ps
`include "dfa_defs.svh"
module dfa_regs
	import dfa_pkg::*;
#(
	parameter logic [7:0] PART_ID = 8'h5a  // arbitrary value
) (
	input  wire logic       clock_i,
	input  wire logic       resetn_i,
	input  wire logic       link_clk_i,
	input  wire logic       link_data_i,
	input  wire logic       halted_i,
	input  wire logic [7:0] si_rev_i,
	input  wire logic       addr_wr_i,
	input  wire logic       data_wr_i,
	input  wire logic       data_rd_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       sfr_rd_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [3:0] sfr_page_i,
	output logic      [7:0] rdata_o,
	output logic            rvalid_o,
	output logic      [7:0] sfr_rdata_o,
	output logic            prog_en_o,
	output logic      [2:0] cmd_o,
	output logic            cmd_valid_o,
	output logic      [7:0] fp_data_o,
	output logic            pins_borrowed_o,
	output logic            link_clk_rise_o,
	output logic            link_data_o
);
	// ---------------------------------------------------------------
	// state and synchronised link levels
	// ---------------------------------------------------------------
	dfa_sync_if sync_bus ();
	dfa_unlock_t unlock_reg;
	logic [7:0]  addr_sel_reg;
	logic [7:0]  fp_ctrl_reg;
	logic [7:0]  fp_data_reg;
	logic        clk_prev_reg;
	logic        cmd_pending_reg;
	dfa_cmd_t    cmd_next;

	// ---------------------------------------------------------------
	// pin synchroniser
	// ---------------------------------------------------------------
	// link pins run off the host's clock, so nothing reads them raw
	dfa_sync u_sync (
		.clock_i     (clock_i),
		.resetn_i    (resetn_i),
		.link_clk_i  (link_clk_i),
		.link_data_i (link_data_i),
		.sync        (sync_bus)
	);

	// ---------------------------------------------------------------
	// command code decoding
	// ---------------------------------------------------------------
	// unknown codes map to none so a stray data byte starts nothing
	function automatic dfa_cmd_t dfa_decode(input logic [7:0] code);
		unique case (code)
			`DFA_CMD_BLOCK_READ:  dfa_decode = DFA_CMD_READ;
			`DFA_CMD_BLOCK_WRITE: dfa_decode = DFA_CMD_WRITE;
			`DFA_CMD_PAGE_ERASE:  dfa_decode = DFA_CMD_PAGE;
			`DFA_CMD_DEV_ERASE:   dfa_decode = DFA_CMD_DEVICE;
			default:              dfa_decode = DFA_CMD_NONE;
		endcase
	endfunction : dfa_decode

	// ---------------------------------------------------------------
	// link pin sampling
	// ---------------------------------------------------------------
	// rise pulse lasts one core cycle at any link rate
	// pins borrowed when halted
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			clk_prev_reg    <= 1'b0;
			link_clk_rise_o <= 1'b0;
			link_data_o     <= 1'b0;
			pins_borrowed_o <= 1'b0;
		end else begin
			clk_prev_reg    <= sync_bus.link_clk;
			link_clk_rise_o <= sync_bus.link_clk & ~clk_prev_reg;
			link_data_o     <= sync_bus.link_data;
			pins_borrowed_o <= halted_i;
		end
	end

	// ---------------------------------------------------------------
	// address select and data registers
	// ---------------------------------------------------------------
	// address select target
	always_ff @(posedge clock_i) begin
		if (!resetn_i)
			addr_sel_reg <= `DFA_ADDR_SEL_RESET;
		else if (addr_wr_i)
			addr_sel_reg <= wdata_i;
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i)
			fp_ctrl_reg <= `DFA_FP_CTRL_RESET;
		else if (data_wr_i && addr_sel_reg == `DFA_ADDR_FP_CTRL)
			fp_ctrl_reg <= wdata_i;
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i)
			unlock_reg <= DFA_LOCKED;
		else if (data_wr_i && addr_sel_reg == `DFA_ADDR_FP_CTRL
			&& unlock_reg != DFA_UNLOCKED) begin
			if (unlock_reg == DFA_HALF && wdata_i == `DFA_UNLOCK_CODE_2)
				unlock_reg <= DFA_UNLOCKED;
			else if (wdata_i == `DFA_UNLOCK_CODE_1)
				unlock_reg <= DFA_HALF;
			else
				unlock_reg <= DFA_LOCKED;
		end
	end

	// registered so the output leaves a flop; costs one cycle
	always_ff @(posedge clock_i) begin
		if (!resetn_i)
			prog_en_o <= 1'b0;
		else
			prog_en_o <= (unlock_reg == DFA_UNLOCKED);
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i)
			fp_data_reg <= `DFA_FP_DATA_RESET;
		else if (data_wr_i && addr_sel_reg == `DFA_ADDR_FP_DATA)
			fp_data_reg <= wdata_i;
	end

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	// first data byte with a known code after an address select write is a command; later bytes are
	// addresses or data and only reach fp_data_o and fp_data_reg
	assign cmd_next = dfa_decode(wdata_i);

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			cmd_o           <= 3'h0;
			cmd_valid_o     <= 1'b0;
			cmd_pending_reg <= 1'b0;
			fp_data_o       <= `DFA_FP_DATA_RESET;
		end else begin
			cmd_valid_o <= 1'b0;
			// clear first: a command in the same cycle leaves it set
			if (addr_wr_i)
				cmd_pending_reg <= 1'b0;
			if (data_wr_i && addr_sel_reg == `DFA_ADDR_FP_DATA) begin
				fp_data_o <= wdata_i;
				if (unlock_reg == DFA_UNLOCKED && !cmd_pending_reg
					&& cmd_next != DFA_CMD_NONE) begin
					cmd_o           <= cmd_next;
					cmd_valid_o     <= 1'b1;
					cmd_pending_reg <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// read paths
	// ---------------------------------------------------------------
	// register readback: part id, revision, fp_ctrl_reg and fp_data_reg
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= data_rd_i;
			if (data_rd_i) begin
				unique case (addr_sel_reg)
					`DFA_ADDR_PART_ID: rdata_o <= PART_ID;
					`DFA_ADDR_SI_REV:  rdata_o <= si_rev_i;
					`DFA_ADDR_FP_CTRL: rdata_o <= fp_ctrl_reg;
					`DFA_ADDR_FP_DATA: rdata_o <= fp_data_reg;
					default:           rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// other pages read zero so the mirror aliases nothing
	// sfr mirror on page f
	always_ff @(posedge clock_i) begin
		if (!resetn_i)
			sfr_rdata_o <= 8'h00;
		else if (sfr_rd_i) begin
			if (sfr_page_i != `DFA_SFR_PAGE_MIRROR)
				sfr_rdata_o <= 8'h00;
			else if (sfr_addr_i == `DFA_ADDR_PART_ID)
				sfr_rdata_o <= PART_ID;
			else if (sfr_addr_i == `DFA_ADDR_SI_REV)
				sfr_rdata_o <= si_rev_i;
			else
				sfr_rdata_o <= 8'h00;
		end
	end
endmodule : dfa_regs

// ==== dv/dfa_regs_chk.sv ====
// Purpose: port checks for the debug flash access registers
// Assumes: one clock domain, sync active-low reset
// Notes:   bound onto every dfa_regs instance
`timescale 1ns/10ps
module dfa_regs_chk
	import dfa_pkg::*;
#(
	parameter logic [7:0] PART_ID = 8'h5a  // arbitrary value
) (
	input wire logic       clock_i,
	input wire logic       resetn_i,
	input wire logic       halted_i,
	input wire logic [7:0] si_rev_i,
	input wire logic       data_wr_i,
	input wire logic       data_rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic       sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [3:0] sfr_page_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       rvalid_o,
	input wire logic       prog_en_o,
	input wire logic [2:0] cmd_o,
	input wire logic       cmd_valid_o,
	input wire logic       pins_borrowed_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	a_read_answer: assert property (data_rd_i |=> rvalid_o)
		else $error("read not answered");
	a_answer_cause: assert property (rvalid_o |-> $past(data_rd_i))
		else $error("answer without read");
	a_unlock_seq: assert property ($rose(prog_en_o) |->
		$past(data_wr_i, 2) && $past(wdata_i, 2) == 8'h01)
		else $error("unlock without code");
	a_unlock_held: assert property (prog_en_o |=> prog_en_o)
		else $error("unlock dropped");
	a_cmd_gated: assert property (cmd_valid_o |->
		prog_en_o && $past(data_wr_i))
		else $error("command while locked");
	a_cmd_legal: assert property (cmd_valid_o |-> cmd_o inside {[1:4]})
		else $error("bad command code");
	a_id_mirror: assert property (sfr_rd_i && sfr_page_i == 4'hf
		&& sfr_addr_i == 8'hfd |=> sfr_rdata_o == PART_ID)
		else $error("id mirror wrong");
	a_rev_mirror: assert property (sfr_rd_i && sfr_page_i == 4'hf
		&& sfr_addr_i == 8'hfe |=> sfr_rdata_o == $past(si_rev_i))
		else $error("revision mirror wrong");
	a_pins_borrow: assert property ($rose(halted_i) |=> pins_borrowed_o)
		else $error("pins not borrowed");
	cover property (cmd_valid_o && cmd_o == 3'h4);
	cover property ($rose(prog_en_o));
	cover property (rvalid_o);
endmodule : dfa_regs_chk
bind dfa_regs dfa_regs_chk #(.PART_ID(PART_ID)) chk (
	.clock_i         (clock_i),
	.resetn_i        (resetn_i),
	.halted_i        (halted_i),
	.si_rev_i        (si_rev_i),
	.data_wr_i       (data_wr_i),
	.data_rd_i       (data_rd_i),
	.wdata_i         (wdata_i),
	.sfr_rd_i        (sfr_rd_i),
	.sfr_addr_i      (sfr_addr_i),
	.sfr_page_i      (sfr_page_i),
	.sfr_rdata_o     (sfr_rdata_o),
	.rvalid_o        (rvalid_o),
	.prog_en_o       (prog_en_o),
	.cmd_o           (cmd_o),
	.cmd_valid_o     (cmd_valid_o),
	.pins_borrowed_o (pins_borrowed_o)
);

// ==== dv/dfa_host_model.sv ====
// Purpose: external programmer driving the debug link pins
// Assumes: link clock stands low between frames
// Notes:   one frame of eight clocks per rise of go_i
`timescale 1ns/10ps
module dfa_host_model (
	input  wire logic go_i,
	output logic      link_clk_o,
	output logic      link_data_o
);
	// data moves only inside a frame
	initial begin
		link_clk_o = 1'b0;
		link_data_o = 1'b1;
		forever begin
			@(posedge go_i);
			repeat (8) begin
				#24 link_clk_o = 1'b1;
				#24 link_clk_o = 1'b0;
				link_data_o = ~link_data_o;
			end
		end
	end
endmodule : dfa_host_model

// ==== dv/testbench.sv ====
// Purpose: self-checking bench for dfa_regs
// Assumes: strobes driven 1 ns after the edge
// Notes:   part id overridden with an arbitrary value
`timescale 1ns/10ps
module testbench;
	import dfa_pkg::*;
	localparam logic [7:0] ID = 8'h4e;  // arbitrary value
	logic clock_i = 0, resetn_i = 0, halted_i = 0, go = 0;
	logic addr_wr_i = 0, data_wr_i = 0, data_rd_i = 0, sfr_rd_i = 0;
	logic [7:0] si_rev_i = 8'h3c, wdata_i = 0, sfr_addr_i = 0;
	logic [3:0] sfr_page_i = 0;
	logic [7:0] rdata_o, sfr_rdata_o, fp_data_o;
	logic [2:0] cmd_o;
	logic rvalid_o, prog_en_o, cmd_valid_o, pins_borrowed_o;
	logic link_clk_rise_o, link_data_o, link_clk_i, link_data_i;
	logic [7:0] cc [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
	int n_errors = 0, comparisons = 0, cycles = 0, rises = 0;
	always #2.5 clock_i = ~clock_i;
	dfa_regs #(.PART_ID(ID)) dut (
		.clock_i         (clock_i),
		.resetn_i        (resetn_i),
		.link_clk_i      (link_clk_i),
		.link_data_i     (link_data_i),
		.halted_i        (halted_i),
		.si_rev_i        (si_rev_i),
		.addr_wr_i       (addr_wr_i),
		.data_wr_i       (data_wr_i),
		.data_rd_i       (data_rd_i),
		.wdata_i         (wdata_i),
		.sfr_rd_i        (sfr_rd_i),
		.sfr_addr_i      (sfr_addr_i),
		.sfr_page_i      (sfr_page_i),
		.rdata_o         (rdata_o),
		.rvalid_o        (rvalid_o),
		.sfr_rdata_o     (sfr_rdata_o),
		.prog_en_o       (prog_en_o),
		.cmd_o           (cmd_o),
		.cmd_valid_o     (cmd_valid_o),
		.fp_data_o       (fp_data_o),
		.pins_borrowed_o (pins_borrowed_o),
		.link_clk_rise_o (link_clk_rise_o),
		.link_data_o     (link_data_o)
	);
	dfa_host_model host (.go_i(go), .link_clk_o(link_clk_i),
		.link_data_o(link_data_i));
	always @(posedge clock_i) begin
		cycles++;
		if (link_clk_rise_o === 1'b1) rises++;
		if (cycles == 4000) begin
			n_errors++;
			wrap_up;
		end
	end
	task wrap_up;
		if (n_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			$display("mismatch %0t got %h want %h", $time, g, e);
			n_errors++;
		end
	endtask : chk
	// kind: 0 address select, 1 data write, 2 data read, 3 sfr read
	task pulse(input int k, input logic [7:0] d);
		@(posedge clock_i) #1;
		wdata_i = d;
		sfr_addr_i = d;
		{addr_wr_i, data_wr_i, data_rd_i, sfr_rd_i} = {k==0, k==1, k==2, k==3};
		@(posedge clock_i) #1;
		{addr_wr_i, data_wr_i, data_rd_i, sfr_rd_i} = 4'h0;
	endtask : pulse
	task rd(input logic [7:0] a, input logic [7:0] e);
		pulse(0, a);
		pulse(2, 8'h00);
		chk(rvalid_o, 8'h01);
		chk(rdata_o, e);
	endtask : rd
	task t_ids;
		rd(8'h02, 8'h00);
		rd(8'hb4, 8'h00);
		pulse(1, 8'h11);
		rd(8'hb4, 8'h11);
		rd(8'h33, 8'h00);
		rd(8'hfd, ID);
		rd(8'hfe, 8'h3c);
		sfr_page_i = 4'hf;
		pulse(3, 8'hfd);
		chk(sfr_rdata_o, ID);
		pulse(3, 8'hfe);
		chk(sfr_rdata_o, 8'h3c);
		sfr_page_i = 4'h0;
		pulse(3, 8'hfd);
		chk(sfr_rdata_o, 8'h00);
	endtask : t_ids
	task t_unlock;
		pulse(0, 8'hb4);
		pulse(1, 8'h06);
		chk(cmd_valid_o, 8'h00);
		pulse(0, 8'h02);
		pulse(1, 8'h02);
		pulse(1, 8'h03);
		pulse(1, 8'h01);
		@(posedge clock_i) #1;
		chk(prog_en_o, 8'h00);
		pulse(1, 8'h02);
		pulse(1, 8'h01);
		@(posedge clock_i) #1;
		chk(prog_en_o, 8'h01);
	endtask : t_unlock
	task t_cmds;
		pulse(0, 8'hb4);
		pulse(1, 8'h05);
		chk(cmd_valid_o, 8'h00);
		for (int i = 0; i < 4; i++) begin
			pulse(0, 8'hb4);
			pulse(1, cc[i]);
			chk(cmd_valid_o, 8'h01);
			chk(cmd_o, 8'(i + 1));
			chk(fp_data_o, cc[i]);
		end
		pulse(1, 8'h07);
		chk(cmd_valid_o, 8'h00);
		rd(8'hb4, 8'h07);
	endtask : t_cmds
	task t_hold;
		halted_i = 1;
		@(posedge clock_i) #1;
		chk(pins_borrowed_o, 8'h01);
		go = 1;
		#180;
		chk(link_data_o, 8'h00);
		#270;
		chk(8'(rises), 8'h08);
		chk(link_data_o, link_data_i);
		chk(prog_en_o, 8'h01);
		halted_i = 0;
		resetn_i = 0;
		repeat (3) @(posedge clock_i);
		#1 resetn_i = 1;
		chk(prog_en_o, 8'h00);
		rd(8'h02, 8'h00);
	endtask : t_hold
	initial begin
		repeat (8) @(posedge clock_i);
		#1 resetn_i = 1;
		t_ids;
		t_unlock;
		t_cmds;
		t_hold;
		wrap_up;
	end
endmodule : testbench
